/* design/hub_desc_defs.vh */
// Register map, reset values and field layout of the hub descriptor
// configuration bank. Definitions only; included by the bank files.
`ifndef HUB_DESC_DEFS_VH
`define HUB_DESC_DEFS_VH

// ==========================================================================
// Register indices (byte registers, byte address = 4 * index)
`define OFS_CTRL_CURRENT_SELF    8'h0e
`define OFS_CTRL_CURRENT_BUS     8'h0f
`define OFS_PORT_POWER_ON_DELAY  8'h10
`define OFS_LANGUAGE_CODE_HIGH   8'h11
`define OFS_LANGUAGE_CODE_LOW    8'h12
`define OFS_MAKER_TEXT_LENGTH    8'h13
`define OFS_PRODUCT_TEXT_LENGTH  8'h14
`define OFS_SERIAL_TEXT_LENGTH   8'h15
`define OFS_MAKER_TEXT_FIRST     8'h16
`define OFS_MAKER_TEXT_LAST      8'h53
`define OFS_HUB_STATUS           8'h60

// ==========================================================================
// Reset values
`define RST_CTRL_CURRENT_SELF    8'h02
`define RST_CTRL_CURRENT_BUS     8'h64
`define RST_PORT_POWER_ON_DELAY  8'h00
`define RST_LANGUAGE_CODE_HIGH   8'h04
`define RST_LANGUAGE_CODE_LOW    8'h09
`define RST_TEXT_LENGTH          8'h00
`define RST_MAKER_TEXT           8'h00

// ==========================================================================
// Field positions and sizes
`define HUB_STATUS_SELF_BIT      0
`define MAKER_TEXT_DEPTH         62
`define MAKER_TEXT_AW            6

`endif

/* design/maker_text_ram.v */
// Byte store for the maker text, UTF-16LE low byte at the even slot.
// Assumes one clock; a read answers one cycle later from a register.
`timescale 1ns/1ps
`include "hub_desc_defs.vh"

module maker_text_ram #(
    parameter DEPTH = `MAKER_TEXT_DEPTH,
    parameter AW    = `MAKER_TEXT_AW
) (
    input  wire          core_clk,
    input  wire          rst,
    input  wire          wr_en,
    input  wire [AW-1:0] wr_addr,
    input  wire [7:0]    wr_data,
    input  wire [AW-1:0] rd_addr,
    output reg  [7:0]    rd_data
);

    reg [7:0] mem [0:DEPTH-1];
    integer   i;

    // ======================================================================
    // Storage and registered read
    // Reset clears every slot so unwritten text reads as zero
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem[i] <= `RST_MAKER_TEXT;
            end
            rd_data <= 8'h00;
        end else begin
            if (wr_en) begin
                mem[wr_addr] <= wr_data;
            end
            rd_data <= mem[rd_addr];
        end
    end

endmodule // maker_text_ram

/* design/hub_descriptor_config_regs.v */
// Byte-wide hub descriptor configuration bank on an Avalon-MM slave,
// with a second read port serving descriptor fields to the hub core.
// Assumes one clock; self_powered is a pin and is synchronised here.
//
// Summary of operation
// - Self-powered controller current, 8 bits in 1 mA, resets to 0x02.
// - Bus-powered controller current, 8 bits in 1 mA, resets to 0x64.
// - Power-on delay in 2 ms units only fills the power-good descriptor field.
// - Language ID is high byte 0x04 and low byte 0x09, giving 0x0409.
// - Three text length registers at 0x13 to 0x15, each reset to zero.
// - Maker text 0x16 to 0x53 holds UTF-16LE, low byte first, packed.
//
// Added by the designer: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "hub_desc_defs.vh"

module hub_descriptor_config_regs (
    input  wire        core_clk,
    input  wire        rst,
    input  wire [9:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    input  wire [3:0]  avs_byteenable,
    output reg  [31:0] avs_readdata,
    output reg         avs_waitrequest,
    output reg  [1:0]  avs_response,
    input  wire        self_powered,
    input  wire [5:0]  desc_text_index,
    output reg  [7:0]  desc_text_byte,
    output reg  [7:0]  desc_ctrl_current,
    output reg  [7:0]  desc_power_on_delay,
    output reg  [15:0] desc_language_code,
    output reg  [7:0]  maker_text_length_value,
    output reg  [7:0]  product_text_length_value,
    output reg  [7:0]  serial_text_length_value
);

    // ======================================================================
    // Bus states
    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_WAIT = 2'b01;
    localparam [1:0] ST_DONE = 2'b10;
    localparam [1:0] ST_ACK  = 2'b11;
    localparam [1:0] RESP_OK  = 2'b00;
    localparam [1:0] RESP_BAD = 2'b10;

    reg  [7:0]  ctrl_current_self_value;
    reg  [7:0]  ctrl_current_bus_value;
    reg  [7:0]  port_power_on_delay;
    reg  [7:0]  language_code_high_value;
    reg  [7:0]  language_code_low_value;
    reg  [1:0]  state;
    reg         self_meta;
    reg         self_sync;
    reg         text_sel;
    reg  [7:0]  reg_rdata;
    reg         reg_hit;
    wire [7:0]  index;
    wire        index_ok;
    wire        in_text;
    wire [5:0]  text_slot;
    wire [7:0]  text_off;
    wire        do_write;
    wire [5:0]  ram_rd_addr;
    wire [7:0]  ram_rd_data;
    reg  [5:0]  core_rd_addr;

    // Byte address bits 9:2 carry the register index; bits 1:0 must be zero
    assign index    = avs_address[9:2];
    assign index_ok = (avs_address[1:0] == 2'b00);

    function in_text_range;
        input [7:0] idx;
        begin
            in_text_range = (idx >= `OFS_MAKER_TEXT_FIRST) &&
                            (idx <= `OFS_MAKER_TEXT_LAST);
        end
    endfunction

    assign in_text   = index_ok && in_text_range(index);
    assign text_off  = index - `OFS_MAKER_TEXT_FIRST;
    assign text_slot = in_text ? text_off[5:0] : 6'd0;
    // Write lands at the edge where the master sees waitrequest low
    assign do_write  = (state == ST_ACK) && avs_write && avs_byteenable[0];

    // Bus reads borrow the RAM port during the request cycle in ST_IDLE; the core port
    // sees the byte of the bus slot for one cycle then, which is harmless for descriptors
    assign ram_rd_addr = (state == ST_IDLE && avs_read && in_text) ?
                         text_slot : core_rd_addr;

    // ======================================================================
    // Maker text store
    maker_text_ram #(
        .DEPTH (`MAKER_TEXT_DEPTH),
        .AW    (`MAKER_TEXT_AW)
    ) u_text (
        .core_clk (core_clk),
        .rst      (rst),
        .wr_en    (do_write && in_text),
        .wr_addr  (text_slot),
        .wr_data  (avs_writedata[7:0]),
        .rd_addr  (ram_rd_addr),
        .rd_data  (ram_rd_data)
    );

    // ======================================================================
    // Power mode pin synchroniser
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            self_meta <= 1'b0;
            self_sync <= 1'b0;
        end else begin
            self_meta <= self_powered;
            self_sync <= self_meta;
        end
    end

    // ======================================================================
    // Register writes; only lane 0 carries data
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ctrl_current_self_value   <= `RST_CTRL_CURRENT_SELF;
            ctrl_current_bus_value    <= `RST_CTRL_CURRENT_BUS;
            port_power_on_delay       <= `RST_PORT_POWER_ON_DELAY;
            language_code_high_value  <= `RST_LANGUAGE_CODE_HIGH;
            language_code_low_value   <= `RST_LANGUAGE_CODE_LOW;
            maker_text_length_value   <= `RST_TEXT_LENGTH;
            product_text_length_value <= `RST_TEXT_LENGTH;
            serial_text_length_value  <= `RST_TEXT_LENGTH;
        end else if (do_write && index_ok) begin
            case (index)
                `OFS_CTRL_CURRENT_SELF:   ctrl_current_self_value <= avs_writedata[7:0];
                `OFS_CTRL_CURRENT_BUS:    ctrl_current_bus_value <= avs_writedata[7:0];
                `OFS_PORT_POWER_ON_DELAY: port_power_on_delay <= avs_writedata[7:0];
                `OFS_LANGUAGE_CODE_HIGH:  language_code_high_value <= avs_writedata[7:0];
                `OFS_LANGUAGE_CODE_LOW:   language_code_low_value <= avs_writedata[7:0];
                `OFS_MAKER_TEXT_LENGTH:   maker_text_length_value <= avs_writedata[7:0];
                `OFS_PRODUCT_TEXT_LENGTH: product_text_length_value <= avs_writedata[7:0];
                `OFS_SERIAL_TEXT_LENGTH:  serial_text_length_value <= avs_writedata[7:0];
                default: ;
            endcase
        end
    end

    // ======================================================================
    // Read decode of flip-flop registers
    always @* begin
        reg_hit   = index_ok;
        reg_rdata = 8'h00;
        case (index)
            `OFS_CTRL_CURRENT_SELF:   reg_rdata = ctrl_current_self_value;
            `OFS_CTRL_CURRENT_BUS:    reg_rdata = ctrl_current_bus_value;
            `OFS_PORT_POWER_ON_DELAY: reg_rdata = port_power_on_delay;
            `OFS_LANGUAGE_CODE_HIGH:  reg_rdata = language_code_high_value;
            `OFS_LANGUAGE_CODE_LOW:   reg_rdata = language_code_low_value;
            `OFS_MAKER_TEXT_LENGTH:   reg_rdata = maker_text_length_value;
            `OFS_PRODUCT_TEXT_LENGTH: reg_rdata = product_text_length_value;
            `OFS_SERIAL_TEXT_LENGTH:  reg_rdata = serial_text_length_value;
            `OFS_HUB_STATUS:          reg_rdata = {7'h00, self_sync};
            default:                  reg_hit = in_text;
        endcase
    end

    // ======================================================================
    // Avalon slave: waitrequest drops one cycle after the take edge,
    // so the text RAM has its registered read cycle before data stands
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state           <= ST_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata    <= 32'h0000_0000;
            avs_response    <= RESP_OK;
            text_sel        <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    avs_waitrequest <= 1'b1;
                    if (avs_read || avs_write) begin
                        text_sel        <= avs_read && in_text;
                        avs_response    <= reg_hit ? RESP_OK : RESP_BAD;
                        // Unmapped reads return zero, not a stray register
                        avs_readdata    <= {24'h000000, reg_hit ? reg_rdata : 8'h00};
                        state           <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    // Text byte read at the take edge is valid now
                    if (text_sel) begin
                        avs_readdata <= {24'h000000, ram_rd_data};
                    end
                    avs_waitrequest <= 1'b0;
                    state           <= ST_ACK;
                end
                ST_ACK: begin
                    // Master samples waitrequest low at this edge
                    avs_waitrequest <= 1'b1;
                    state           <= ST_DONE;
                end
                ST_DONE: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state           <= ST_IDLE;
                    avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // ======================================================================
    // Descriptor side outputs
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            desc_ctrl_current   <= `RST_CTRL_CURRENT_BUS;
            desc_power_on_delay <= `RST_PORT_POWER_ON_DELAY;
            desc_language_code  <= {`RST_LANGUAGE_CODE_HIGH, `RST_LANGUAGE_CODE_LOW};
            desc_text_byte      <= 8'h00;
            core_rd_addr        <= 6'd0;
        end else begin
            desc_ctrl_current   <= self_sync ? ctrl_current_self_value
                                             : ctrl_current_bus_value;
            desc_power_on_delay <= port_power_on_delay;
            desc_language_code  <= {language_code_high_value, language_code_low_value};
            core_rd_addr        <= desc_text_index;
            desc_text_byte      <= ram_rd_data;
        end
    end

endmodule // hub_descriptor_config_regs

/* testbench/hub_regs_properties.sv */
// Checker for the hub descriptor bank, bound to its ports.
// Assumes one clock and the two-wait-cycle slave timing.
`timescale 1ns/1ps

module hub_regs_checker (
    input wire        core_clk,
    input wire        rst,
    input wire [9:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0]  avs_byteenable,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    input wire [1:0]  avs_response,
    input wire        self_powered,
    input wire [7:0]  desc_ctrl_current,
    input wire [7:0]  desc_power_on_delay,
    input wire [15:0] desc_language_code,
    input wire [7:0]  maker_text_length_value,
    input wire [7:0]  product_text_length_value,
    input wire [7:0]  serial_text_length_value
);
    reg  [7:0] self_v;
    reg  [7:0] bus_v;
    wire [7:0] idx = avs_address[9:2];
    wire       wdone = !avs_waitrequest && avs_write && avs_byteenable[0];
    wire       ok = avs_address[1:0] == 2'b00 && (idx == 8'h60 || (idx > 8'h0d && idx < 8'h54));
    // ==========================================
    // Shadows of both currents, updated at the same edge as the registers
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            self_v <= 8'h02;
            bus_v  <= 8'h64;
        end else if (wdone && avs_address == 10'h038) begin
            self_v <= avs_writedata[7:0];
        end else if (wdone && avs_address == 10'h03c) begin
            bus_v <= avs_writedata[7:0];
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence take_s;
        $rose(avs_read || avs_write);
    endsequence
    sequence answer_s;
        avs_waitrequest ##1 !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence rd_done_s;
        !avs_waitrequest && avs_read;
    endsequence
    property mirror_p(a, v);
        rd_done_s and avs_address == a |-> avs_readdata[7:0] == v;
    endproperty
    property reset_seen_p;
        $fell(rst) |-> avs_waitrequest && desc_ctrl_current == 8'h64
            && desc_language_code == 16'h0409;
    endproperty
    // ==========================================
    // Assertions
    take_answer_a: assert property (take_s |=> answer_s)
        else $error("waitrequest not low for one cycle two cycles after a request");
    self_current_a: assert property (self_powered [*4] |-> ##[0:2] desc_ctrl_current == self_v)
        else $error("descriptor current not the self-powered value");
    bus_current_a: assert property (!self_powered [*4] |-> ##[0:2] desc_ctrl_current == bus_v)
        else $error("descriptor current not the bus-powered value");
    unmapped_resp_a: assert property (rd_done_s |-> avs_response == (ok ? 2'b00 : 2'b10))
        else $error("wrong read response code");
    unmapped_zero_a: assert property (rd_done_s and !ok |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    upper_zero_a: assert property (rd_done_s |-> avs_readdata[31:8] == 24'h0)
        else $error("read data upper bytes not zero");
    delay_copy_a: assert property (mirror_p(10'h040, desc_power_on_delay))
        else $error("power-on delay field differs from register");
    lang_high_a: assert property (mirror_p(10'h044, desc_language_code[15:8]))
        else $error("language high byte differs");
    lang_low_a: assert property (mirror_p(10'h048, desc_language_code[7:0]))
        else $error("language low byte differs");
    maker_len_a: assert property (mirror_p(10'h04c, maker_text_length_value))
        else $error("maker length differs");
    product_len_a: assert property (mirror_p(10'h050, product_text_length_value))
        else $error("product length differs");
    serial_len_a: assert property (mirror_p(10'h054, serial_text_length_value))
        else $error("serial length differs");
    reset_state_a: assert property (reset_seen_p)
        else $error("wrong state after reset");
endmodule // hub_regs_checker

bind hub_descriptor_config_regs hub_regs_checker chk (.core_clk, .rst, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response,
    .self_powered, .desc_ctrl_current, .desc_power_on_delay, .desc_language_code,
    .maker_text_length_value, .product_text_length_value, .serial_text_length_value);

/* testbench/desc_host_model.sv */
// Upstream host model fetching maker text characters from the bank.
// Assumes a text byte stands three edges after its index is set.
`timescale 1ns/1ps

module desc_host_model (
    input  wire       core_clk,
    output reg  [5:0] desc_text_index,
    input  wire [7:0] desc_text_byte
);
    initial desc_text_index = 6'h00;
    // ==========================================
    // Character fetch, slow adds idle cycles
    // low byte first
    task automatic get_char(input [5:0] n, input integer slow, output [15:0] c);
        integer i;
        for (i = 0; i < 2; i = i + 1) begin
            @(posedge core_clk);
            desc_text_index <= {n[4:0], i[0]};
            // Index flop, RAM read and output flop: byte stands after the third, sample after the fourth
            repeat (4 + slow) @(posedge core_clk);
            c[8*i +: 8] = desc_text_byte;
        end
    endtask
endmodule // desc_host_model

/* testbench/hub_descriptor_config_regs_test.sv */
// Self-checking bench for the hub descriptor bank.
// Assumes a 10 MHz clock and the host model on the text port.
`timescale 1ns/1ps

module hub_descriptor_config_regs_test;
    reg         core_clk, rst, avs_read, avs_write, self_powered;
    reg  [9:0]  avs_address;
    reg  [31:0] avs_writedata, seed, rd;
    reg  [3:0]  avs_byteenable;
    reg  [15:0] ch;
    reg  [1:0]  rs;
    wire [31:0] avs_readdata;
    wire        avs_waitrequest;
    wire [1:0]  avs_response;
    wire [5:0]  tidx;
    wire [7:0]  tbyte, cur, dly, mlen, plen, slen;
    wire [15:0] lang;
    integer     fails, total_checks, i, mem [0:255];

    hub_descriptor_config_regs dut (.core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .avs_response(avs_response),
        .self_powered(self_powered), .desc_text_index(tidx), .desc_text_byte(tbyte),
        .desc_ctrl_current(cur), .desc_power_on_delay(dly), .desc_language_code(lang),
        .maker_text_length_value(mlen), .product_text_length_value(plen),
        .serial_text_length_value(slen));
    desc_host_model host (.core_clk(core_clk), .desc_text_index(tidx), .desc_text_byte(tbyte));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task check(input string what, input [31:0] exp, input [31:0] got);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("Error %0s expected %h seen %h", what, exp, got);
        end
    endtask
    // ==========================================
    // Bus cycle, held until waitrequest is seen low
    task automatic bus(input w, input [7:0] x, input [7:0] d, input [1:0] lo, input [3:0] be);
        integer n;
        n = 0;
        avs_address <= {x, lo};
        avs_read <= !w;
        avs_write <= w;
        avs_writedata <= {seed[31:8], d}; // Junk upper bytes must be dropped
        avs_byteenable <= be;
        do begin
            @(posedge core_clk);
            n = n + 1;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) fails = fails + 1;
        rd = avs_readdata;
        rs = avs_response;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge core_clk);
    endtask
    task wr(input [7:0] x, input [7:0] d, input [3:0] be);
        bus(1'b1, x, d, 2'b00, be);
        if (be[0] && x > 8'h0d && x < 8'h54) mem[x] = d;
    endtask
    task rdchk(input [7:0] x, input [1:0] lo);
        reg ok;
        ok = lo == 2'b00 && (x == 8'h60 || (x > 8'h0d && x < 8'h54));
        bus(1'b0, x, 8'h00, lo, 4'hf);
        check("readdata", ok ? mem[x] : 0, rd);
        check("response", ok ? 0 : 2, {30'h0, rs});
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Whole run is under a thousand cycles
    initial begin
        repeat (5000) @(posedge core_clk);
        fails = fails + 1;
        end_sim;
    end
    // ==========================================
    // Main sequence
    initial begin
        {rst, avs_read, avs_write, self_powered} = 4'h8;
        {avs_address, avs_writedata, avs_byteenable} = 46'h0;
        fails = 0;
        total_checks = 0;
        seed = 32'hc40e3ed7;
        for (i = 0; i < 256; i = i + 1) mem[i] = 0;
        {mem[8'h0e], mem[8'h0f], mem[8'h11], mem[8'h12]} = {32'h2, 32'h64, 32'h4, 32'h9};
        repeat (8) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        for (i = 8'h0d; i < 8'h17; i = i + 1) rdchk(i, 2'b00);
        // Random currents stand for the whole board draw, self value capped
        for (i = 8'h0e; i < 8'h54; i = i + 1) begin
            seed = lfsr(seed);
            wr(i, i == 8'h0e ? seed[7:0] % 8'd101 : seed[7:0], 4'hf);
        end
        wr(8'h0e, seed[15:8] % 8'd101, 4'hf);
        check("delay", mem[8'h10], dly);
        check("language", {mem[8'h11][7:0], mem[8'h12][7:0]}, lang);
        check("maker length", mem[8'h13], {24'h0, mlen});
        check("product length", mem[8'h14], {24'h0, plen});
        check("serial length", mem[8'h15], {24'h0, slen});
        wr(8'h10, 8'h00, 4'hf);
        wr(8'h13, 8'h5a, 4'he);
        wr(8'h54, 8'h5a, 4'hf);
        for (i = 8'h0d; i < 8'h55; i = i + 1) rdchk(i, 2'b00);
        rdchk(8'h0e, 2'b01);
        for (i = 0; i < 31; i = i + 15) begin
            host.get_char(i, i == 15 ? 4 : 0, ch);
            check("text char", {mem[8'h17 + 2 * i][7:0], mem[8'h16 + 2 * i][7:0]}, ch);
        end
        for (i = 1; i >= 0; i = i - 1) begin
            self_powered <= i[0];
            repeat (4) @(posedge core_clk);
            mem[8'h60] = i;
            wr(8'h60, 8'hfe, 4'hf);
            rdchk(8'h60, 2'b00);
            check("current", mem[i ? 8'h0e : 8'h0f], cur);
        end
        end_sim;
    end
endmodule // hub_descriptor_config_regs_test
